// ==== hdl/adc_timing_and_interrupt_ctrl.sv ====
// Conversion sequencer: timing selection, phase counting and request flags.
// Assumes a one-cycle start pulse per request and synchronous inputs.
//
// Function
// [RULE1] Standard clock select 15..14: 00 /4, 01 /2, 10 /16, 11 /8.
// [RULE2] Standard sample select 13..12: 8, 16, 32, 64 basic periods.
// [RULE3] Improved timing when select bit set in compat mode, or enhanced mode.
// [RULE4] Improved timing ignores both 2-bit standard fields.
// [RULE5] Compat improved timing applies one 6-bit set to all conversions.
// [RULE6] Enhanced mode: standard set for standard, injected set for injected.
// [RULE7] Improved divider: module clock divided by field plus one.
// [RULE8] Improved sample: four times field plus two basic periods; the code adds eight, not two.
// [RULE9] Total: sample, 52/40/44/32 basic periods, plus six module cycles.
// [RULE10] Each conversion samples first, then approximation steps per resolution.
// [RULE11] Every conversion completion sets the end-of-conversion flag.
// [RULE12] Standard mode: overwriting an unread result sets the error flag.
// [RULE13] Injected result written to alternate register sets error flag.
// [RULE14] Channel-31 event and timer period match trigger injected conversions.
// [RULE15] Two separate request outputs: end of conversion, error/injection.
// [RULE16] Injected result goes straight to alternate register, overwriting.
// [RULE17] Post-calibration disable skips calibration cycles.
// [RULE18] Basic clock is a prescaler enable; all logic on module clock.
`timescale 1ns/1ns
module adc_timing_and_interrupt_ctrl
   import adc_timing_pkg::*;
#(
   parameter int RES_W = 10
) (
   // Clock and reset
   input  wire logic             clock_i,
   input  wire logic             rst_i,
   // Control word and modes
   input  wire logic [15:0]      converter_control_reg_i,
   input  wire logic             improved_timing_select_i,
   input  wire logic             enhanced_mode_select_i,
   input  wire logic             post_calibration_disable_i,
   input  wire logic             res_8bit_i,
   input  wire logic             inject_enable_i,
   // Improved timing fields
   input  wire logic [5:0]       compat_div_i,
   input  wire logic [5:0]       compat_sample_i,
   input  wire logic [5:0]       std_div_i,
   input  wire logic [5:0]       std_sample_i,
   input  wire logic [5:0]       inj_div_i,
   input  wire logic [5:0]       inj_sample_i,
   // Requests and triggers
   input  wire logic             start_i,
   input  wire logic             inject_req_i,
   input  wire logic             capcmp_channel31_event_i,
   input  wire logic             pwm_timer_period_match_i,
   // Analog result and software reads
   input  wire logic [RES_W-1:0] analog_result_i,
   input  wire logic             result_read_i,
   input  wire logic             eoc_clear_i,
   input  wire logic             error_clear_i,
   // Status and results
   output logic                  busy_o,
   output logic                  sampling_o,
   output logic [RES_W-1:0]      result_reg_o,
   output logic [RES_W-1:0]      alternate_result_reg_o,
   output logic                  end_of_conversion_flag_o,
   output logic                  overrun_or_inject_done_flag_o
);

   // Refused at elaboration
   if (RES_W < 8) begin : gen_res_w_check
      $error("RES_W must be at least 8");
   end

   conv_state_t      state_reg, state_next;
   logic [8:0]       count_reg, count_next;
   logic             inj_reg, inj_next;
   logic             pend_reg, pend_next;
   logic             unread_reg, unread_next;
   logic [RES_W-1:0] res_reg, res_next;
   logic [RES_W-1:0] alt_reg, alt_next;
   logic             eoc_reg, eoc_next;
   logic             err_reg, err_next;
   logic             busy_reg, busy_next;
   logic             smp_reg, smp_next;

   logic             improved;
   logic [5:0]       div_m1;
   logic [8:0]       sample_len;
   logic [6:0]       approx_len;
   logic             tick;
   logic             inj_trigger;
   logic             store_std;
   logic             store_inj;

   assign improved = (improved_timing_select_i & ~enhanced_mode_select_i)
                     | enhanced_mode_select_i; // [RULE3]
   assign inj_trigger = inject_req_i | capcmp_channel31_event_i
                        | pwm_timer_period_match_i; // [RULE14]

   // Timing selection
   always_comb begin
      div_m1     = DIV_RESET;
      sample_len = STD_SAMPLE_BASE;
      if (!improved) begin
         case (converter_control_reg_i[CLKSEL_HI:CLKSEL_LO]) // [RULE1]
            2'b00:   div_m1 = 6'h03;
            2'b01:   div_m1 = 6'h01;
            2'b10:   div_m1 = 6'h0F;
            default: div_m1 = 6'h07;
         endcase
         sample_len = STD_SAMPLE_BASE
                      << converter_control_reg_i[SMPSEL_HI:SMPSEL_LO]; // [RULE2]
      end else if (enhanced_mode_select_i) begin
         div_m1     = inj_reg ? inj_div_i : std_div_i; // [RULE6] [RULE4]
         sample_len = {1'b0, (inj_reg ? inj_sample_i : std_sample_i), 2'b00}
                      + 9'h008; // [RULE8]
      end else begin
         div_m1     = compat_div_i; // [RULE5] [RULE7]
         sample_len = {1'b0, compat_sample_i, 2'b00} + 9'h008; // [RULE8]
      end
   end

   // Approximation plus calibration length
   always_comb begin
      case ({res_8bit_i, post_calibration_disable_i}) // [RULE9] [RULE17]
         2'b00:   approx_len = APPROX_10_CAL;
         2'b01:   approx_len = APPROX_10_NOCAL;
         2'b10:   approx_len = APPROX_8_CAL;
         default: approx_len = APPROX_8_NOCAL;
      endcase
   end

   basic_clock_prescaler #(
      .DIV_W (6)
   ) u_prescaler (
      .clock_i         (clock_i),
      .rst_i           (rst_i),
      .run_i           (state_reg == ST_SAMPLE || state_reg == ST_CONVERT),
      .divide_minus1_i (div_m1),
      .tick_o          (tick)
   ); // [RULE18]

   always_comb begin
      state_next  = state_reg;
      count_next  = count_reg;
      inj_next    = inj_reg;
      pend_next   = pend_reg | (inj_trigger & inject_enable_i);
      unread_next = unread_reg & ~result_read_i;
      res_next    = res_reg;
      alt_next    = alt_reg;
      eoc_next    = eoc_reg & ~eoc_clear_i;
      err_next    = err_reg & ~error_clear_i;
      store_std   = 1'b0;
      store_inj   = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            count_next = '0;
            if (pend_reg) begin
               inj_next   = 1'b1;
               // A trigger in the serving cycle is kept, set wins
               pend_next  = inj_trigger & inject_enable_i; // [RULE14]
               state_next = ST_SAMPLE; // [RULE10]
            end else if (start_i) begin
               inj_next   = 1'b0;
               state_next = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            if (tick) begin
               if (count_reg + 9'h001 >= sample_len) begin
                  count_next = '0;
                  state_next = ST_CONVERT; // [RULE10]
               end else begin
                  count_next = count_reg + 9'h001;
               end
            end
         end
         ST_CONVERT: begin
            if (tick) begin
               if (count_reg + 9'h001 >= {2'b00, approx_len}) begin
                  count_next = '0;
                  state_next = ST_TRANSFER; // [RULE9]
               end else begin
                  count_next = count_reg + 9'h001;
               end
            end
         end
         ST_TRANSFER: begin
            if (count_reg + 9'h001 >= {6'h00, TRANSFER_CYCLES}) begin // [RULE9]
               count_next = '0;
               state_next = ST_IDLE;
               store_inj  = inj_reg;
               store_std  = ~inj_reg;
            end else begin
               count_next = count_reg + 9'h001;
            end
         end
         default: state_next = ST_IDLE;
      endcase
      // Flag sets after clears so a simultaneous event is not lost
      if (store_std) begin
         res_next    = analog_result_i;
         eoc_next    = 1'b1; // [RULE11]
         if (unread_reg && !result_read_i)
            err_next = 1'b1; // [RULE12]
         unread_next = 1'b1;
      end
      if (store_inj) begin
         alt_next = analog_result_i; // [RULE16]
         eoc_next = 1'b1; // [RULE11]
         err_next = 1'b1; // [RULE13]
      end
      busy_next = (state_next != ST_IDLE);
      smp_next  = (state_next == ST_SAMPLE);
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state_reg  <= ST_IDLE;
         count_reg  <= '0;
         inj_reg    <= 1'b0;
         pend_reg   <= 1'b0;
         unread_reg <= 1'b0;
         res_reg    <= '0;
         alt_reg    <= '0;
         eoc_reg    <= 1'b0;
         err_reg    <= 1'b0;
         busy_reg   <= 1'b0;
         smp_reg    <= 1'b0;
      end else begin
         state_reg  <= state_next;
         count_reg  <= count_next;
         inj_reg    <= inj_next;
         pend_reg   <= pend_next;
         unread_reg <= unread_next;
         res_reg    <= res_next;
         alt_reg    <= alt_next;
         eoc_reg    <= eoc_next;
         err_reg    <= err_next;
         busy_reg   <= busy_next;
         smp_reg    <= smp_next;
      end
   end

   // Two separate request lines
   assign end_of_conversion_flag_o      = eoc_reg; // [RULE15]
   assign overrun_or_inject_done_flag_o = err_reg; // [RULE15]
   assign result_reg_o                  = res_reg;
   assign alternate_result_reg_o        = alt_reg;
   assign busy_o                        = busy_reg;
   assign sampling_o                    = smp_reg;

endmodule // adc_timing_and_interrupt_ctrl

// ==== hdl/adc_timing_pkg.sv ====
// Package for the converter timing and interrupt-request block.
// Holds field positions, timing codes and cycle counts shared by the design files.
package adc_timing_pkg;

   // Standard timing control word fields
   localparam int CLKSEL_HI = 15;
   localparam int CLKSEL_LO = 14;
   localparam int SMPSEL_HI = 13;
   localparam int SMPSEL_LO = 12;

   // Conversion phase lengths in basic-clock periods
   localparam logic [6:0] APPROX_10_CAL   = 7'h34;  // 52
   localparam logic [6:0] APPROX_10_NOCAL = 7'h28;  // 40
   localparam logic [6:0] APPROX_8_CAL    = 7'h2C;  // 44
   localparam logic [6:0] APPROX_8_NOCAL  = 7'h20;  // 32

   // Result transfer length in module-clock periods
   localparam logic [2:0] TRANSFER_CYCLES = 3'h6;

   // Standard sample lengths
   localparam logic [8:0] STD_SAMPLE_BASE = 9'h008;

   // Reset values
   localparam logic [5:0] DIV_RESET = 6'h00;

   typedef enum logic [3:0] {
      ST_IDLE     = 4'b0001,
      ST_SAMPLE   = 4'b0010,
      ST_CONVERT  = 4'b0100,
      ST_TRANSFER = 4'b1000
   } conv_state_t;

endpackage

// ==== hdl/basic_clock_prescaler.sv ====
// Prescaler producing the basic conversion clock as a one-cycle enable.
// Assumes divide ratio is held stable by the caller while running.
`timescale 1ns/1ns
module basic_clock_prescaler
   import adc_timing_pkg::*;
#(
   parameter int DIV_W = 6
) (
   // Clock and reset
   input  wire logic             clock_i,
   input  wire logic             rst_i,
   // Control
   input  wire logic             run_i,
   input  wire logic [DIV_W-1:0] divide_minus1_i,
   // Enable out
   output logic                  tick_o
);

   // Refused at elaboration
   if (DIV_W < 1 || DIV_W > 16) begin : gen_div_w_check
      $error("DIV_W out of range");
   end

   logic [DIV_W-1:0] count_reg;
   logic [DIV_W-1:0] count_next;
   logic             tick_reg;
   logic             tick_next;

   always_comb begin
      count_next = count_reg;
      tick_next  = 1'b0;
      if (!run_i) begin
         count_next = '0;
      end else if (count_reg >= divide_minus1_i) begin
         count_next = '0;
         tick_next  = 1'b1;
      end else begin
         count_next = count_reg + 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         count_reg <= '0;
         tick_reg  <= 1'b0;
      end else begin
         count_reg <= count_next;
         tick_reg  <= tick_next;
      end
   end

   assign tick_o = tick_reg;

endmodule // basic_clock_prescaler

// ==== verif/adc_timing_properties.sv ====
// Port checker for the converter sequencer.
// Bound to the sequencer; sees its ports only.
`timescale 1ns/1ns
module adc_timing_properties #(
   parameter int RES_W = 10
) (
   input wire logic             clock_i,
   input wire logic             rst_i,
   input wire logic             start_i,
   input wire logic             eoc_clear_i,
   input wire logic             error_clear_i,
   input wire logic             busy_o,
   input wire logic             sampling_o,
   input wire logic [RES_W-1:0] result_reg_o,
   input wire logic [RES_W-1:0] alternate_result_reg_o,
   input wire logic             end_of_conversion_flag_o,
   input wire logic             overrun_or_inject_done_flag_o
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   AST_START: assert property (start_i && !busy_o |=> busy_o)
      else $error("start not taken");
   AST_SAMPLE_FIRST: assert property ($rose(busy_o) |-> sampling_o)
      else $error("no sample phase first");
   AST_SMP_IN_BUSY: assert property (sampling_o |-> busy_o)
      else $error("sampling while idle");
   AST_MIN_LEN: assert property ($rose(busy_o) |-> busy_o[*8])
      else $error("conversion too short");
   AST_EOC_SET: assert property ($fell(busy_o) |-> end_of_conversion_flag_o)
      else $error("end flag not set");
   AST_EOC_HOLD: assert property (
      end_of_conversion_flag_o && !eoc_clear_i |=> end_of_conversion_flag_o)
      else $error("end flag dropped");
   AST_ERR_HOLD: assert property (
      overrun_or_inject_done_flag_o && !error_clear_i |=> overrun_or_inject_done_flag_o)
      else $error("error flag dropped");
   AST_ALT_ERR: assert property (
      $changed(alternate_result_reg_o) |-> overrun_or_inject_done_flag_o)
      else $error("injected store without error flag");
   AST_RES_END: assert property ($changed(result_reg_o) |-> $fell(busy_o))
      else $error("result stored mid conversion");
endmodule // adc_timing_properties

bind adc_timing_and_interrupt_ctrl adc_timing_properties #(.RES_W(RES_W)) props (
   .clock_i(clock_i), .rst_i(rst_i), .start_i(start_i),
   .eoc_clear_i(eoc_clear_i), .error_clear_i(error_clear_i),
   .busy_o(busy_o), .sampling_o(sampling_o), .result_reg_o(result_reg_o),
   .alternate_result_reg_o(alternate_result_reg_o),
   .end_of_conversion_flag_o(end_of_conversion_flag_o),
   .overrun_or_inject_done_flag_o(overrun_or_inject_done_flag_o));

// ==== verif/trig_model.sv ====
// Trigger sources and interrupt controller seen by the sequencer.
// Fires one-cycle pulses on command; counts raised end requests.
`timescale 1ns/1ns
module trig_model (
   input  wire logic       clock_i,
   input  wire logic [1:0] fire_i,
   input  wire logic       eoc_i,
   output logic            cc_event_o = 1'b0,
   output logic            period_match_o = 1'b0,
   output logic [7:0]      eoc_count_o = 8'h00
);
   logic eoc_reg = 1'b0;
   always @(posedge clock_i) begin
      cc_event_o <= (fire_i == 2'h1);
      period_match_o <= (fire_i == 2'h2);
      eoc_reg <= eoc_i;
      if (eoc_i && !eoc_reg)
         eoc_count_o <= eoc_count_o + 8'h01;
   end
endmodule // trig_model

// ==== verif/testbench.sv ====
// Self-checking bench for the converter sequencer.
// Assumes package, design, checker and trigger model compiled first.
`timescale 1ns/1ns
module testbench;
   logic clk, rst, its, ems, pcd, r8, ien, st, ir, rd, ec, erc, busy, smp, eoc, err, cc, pm;
   logic [15:0] ctl;
   logic [5:0]  tf [6];
   logic [9:0]  ar, res, alt;
   logic [1:0]  fire;
   logic [7:0]  icnt;
   int          num_errors, checked, cyc, nconv, sc, sh;
   int          dt [4] = '{4, 2, 16, 8};
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   adc_timing_and_interrupt_ctrl #(.RES_W(10)) uut (
      .clock_i(clk), .rst_i(rst), .converter_control_reg_i(ctl),
      .improved_timing_select_i(its), .enhanced_mode_select_i(ems),
      .post_calibration_disable_i(pcd), .res_8bit_i(r8), .inject_enable_i(ien),
      .compat_div_i(tf[0]), .compat_sample_i(tf[1]), .std_div_i(tf[2]),
      .std_sample_i(tf[3]), .inj_div_i(tf[4]), .inj_sample_i(tf[5]),
      .start_i(st), .inject_req_i(ir), .capcmp_channel31_event_i(cc),
      .pwm_timer_period_match_i(pm), .analog_result_i(ar), .result_read_i(rd),
      .eoc_clear_i(ec), .error_clear_i(erc), .busy_o(busy), .sampling_o(smp),
      .result_reg_o(res), .alternate_result_reg_o(alt),
      .end_of_conversion_flag_o(eoc), .overrun_or_inject_done_flag_o(err));
   trig_model partner (.clock_i(clk), .fire_i(fire), .eoc_i(eoc),
      .cc_event_o(cc), .period_match_o(pm), .eoc_count_o(icnt));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t %h %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Flags cleared first so every run raises a fresh end request
   task automatic conv(input int k, input int d, input int s, input logic rf);
      int a, n, m;
      @(posedge clk);
      a = r8 ? (pcd ? 32 : 44) : (pcd ? 40 : 52);
      {ec, erc, rd} <= {2'b11, rf};
      ar <= 10'($urandom);
      @(posedge clk);
      {ec, erc, rd} <= 3'b000;
      {st, ir} <= {k == 0, k == 1};
      fire <= (k > 1) ? 2'(k - 1) : 2'h0;
      @(posedge clk);
      {st, ir, fire} <= 4'h0;
      n = 0;
      while (busy !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      n = 0;
      m = 0;
      while (busy === 1'b1 && n < 30000) begin
         m += (smp === 1'b1);
         @(negedge clk);
         n++;
      end
      nconv++;
      // Up to two extra cycles allowed for the registered basic-clock enable
      chk(n >= d * (s + a) + 6 && n <= d * (s + a) + 8, 1);
      chk(m >= d * s && m <= d * s + 2, 1);
      chk(eoc, 1);
      chk(k ? alt : res, ar);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc > 40000) begin
         num_errors++;
         report_and_stop;
      end
   end
   initial begin
      {its, ems, pcd, r8, ien, st, ir, rd, ec, erc} = '0;
      {ctl, ar, fire, cyc, num_errors, checked, nconv} = '0;
      tf = '{default: '0};
      rst = 1'b1;
      void'($urandom(36058));
      sh = $urandom % 4;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk({busy, smp, eoc, err, res, alt}, 0);
      // Rotating start so every sample code is met once
      for (int c = 0; c < 4; c++) begin
         @(posedge clk);
         sc = (c + sh) % 4;
         ctl <= {2'(c), 2'(sc), 12'($urandom)};
         {pcd, r8} <= 2'($urandom);
         conv(0, dt[c], 8 << sc, 1);
      end
      @(posedge clk);
      {ctl, pcd} <= {16'h4000, 1'b1};
      conv(0, 2, 8, 1);
      chk(err, 0);
      conv(0, 2, 8, 0);
      chk(err, 1);
      // One trigger pulse while injection is disabled
      @(posedge clk);
      fire <= 2'h1;
      @(posedge clk);
      fire <= 2'h0;
      repeat (10) @(negedge clk);
      chk(busy, 0);
      @(posedge clk);
      {its, ien, ctl, tf[0], tf[1]} <= {2'b11, 16'($urandom), 6'($urandom % 4), 6'h3};
      @(negedge clk);
      conv(0, tf[0] + 1, 20, 1);
      conv(1, tf[0] + 1, 20, 1);
      chk(err, 1);
      @(posedge clk);
      {its, ems, tf[2], tf[3], tf[4], tf[5]} <= {2'b01, 6'h0, 6'h0, 6'h3, 6'h5};
      conv(0, 1, 8, 1);
      conv(2, 4, 28, 1);
      conv(3, 4, 28, 1);
      chk(err, 1);
      // Reset lands while a fresh conversion runs
      @(posedge clk);
      st <= 1'b1;
      @(posedge clk);
      st <= 1'b0;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk({busy, smp, eoc, err, res, alt, icnt}, {24'h000000, 8'(nconv)});
      report_and_stop;
   end
endmodule // testbench
